/* File: verilog/hsrfd_consts.svh */
// Constants of the host serial receive, flow and splitter block.
// Functional notes
// [R1] Default pool is eight buffers of 48 bytes.
// [R2] Fill first free buffer, then the next.
// [R3] All buffers full: drop incoming characters.
// [R4] Send suspend when free count equals stop-threshold.
// [R5] Send resume when free count equals go-threshold.
// [R6] Received suspend blocks our transmission.
// [R7] Reconfigure, query or reboot releases suspension.
// [R8] Received flow characters ignored after reset.
// [R9] Count characters lost for lack of buffers.
// [R10] Sticky parity, framing, overrun flags since boot.
// [R11] Parity bit follows data bits, lsb first.
// [R12] Even or odd count of ones over 8 bits; the code counts over 7 bits in seven-bit mode.
// [R13] Receiver flags parity mismatch.
// [R14] Odd, even or no parity.
// [R15] Line idles at mark; start is space.
// [R16] Missing stop bit sets framing flag.
// [R17] Unread holding register overwritten, overrun flagged.
// [R18] Stage one passes bytes until count start.
// [R19] Stage two passes to terminal until escape start.
// [R20] First block carries routing byte, continuations inherit.
// [R21] Start characters programmable through configuration inputs.
// [R22] Count mode counts bytes without inspecting them.
// [R23] Suspend character defaults to 19.
// [R24] Resume character defaults to 17.
// [R25] Stop own transmission within one character time.
// [R26] Release partial buffer after two idle character times.
// [R27] Pool and flow settings writable, reset to defaults.
`ifndef HSRFD_CONSTS_SVH
`define HSRFD_CONSTS_SVH
`define HSRFD_CLK_PERIOD_NS 40
`define HSRFD_NUM_BUF_DEF 4'h8
`define HSRFD_BUF_SIZE_DEF 6'h30
`define HSRFD_BUF_STRIDE 9'h030
`define HSRFD_MEM_DEPTH 384
`define HSRFD_STOP_THR_DEF 4'h1
`define HSRFD_GO_THR_DEF 4'h2
`define HSRFD_XON_DEF 8'h11
`define HSRFD_XOFF_DEF 8'h13
`define HSRFD_CNT_START_DEF 8'h06
`define HSRFD_ESC_START_DEF 8'h1c
`define HSRFD_BAUD_DIV_DEF 16'h0516
`define HSRFD_IDLE_CHARS 5'h02
`define HSRFD_LOST_MAX 16'hffff
`endif

/* File: verilog/hsrfd_pkg.sv */
// Types shared by the host serial receive, flow and splitter block.
package hsrfd_pkg;
  typedef enum logic [1:0] {
    PAR_NONE,
    PAR_EVEN,
    PAR_ODD
  } hsrfd_parity_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    hsrfd_rx_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} hsrfd_tx_t;
  typedef enum logic [1:0] {SP_TERM, SP_CNT_LEN, SP_CNT_DATA, SP_ESC}
    hsrfd_split_t;
endpackage

/* File: verilog/hsrfd_buf_mem.sv */
// Receive buffer pool storage with a registered read port.
`include "hsrfd_consts.svh"
module hsrfd_buf_mem (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [8:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic rdEn,
  input wire logic [8:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [0:`HSRFD_MEM_DEPTH-1];

  // Write and read ports work independently; read data is registered.
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule

/* File: verilog/hsrfd_serial_port.sv */
// Host serial port: receiver, buffer pool, flow control and splitters.
`include "hsrfd_consts.svh"
module hsrfd_serial_port (
  input wire logic clk,
  input wire logic rstn,
  input wire logic serialIn,
  output logic serialOut,
  input wire logic cfgLoad,
  input wire logic cfgQuery,
  input wire logic [15:0] cfgBaudDiv,
  input wire logic [1:0] cfgParity,
  input wire logic cfgSevenBit,
  input wire logic cfgFlowOut,
  input wire logic cfgHearFlow,
  input wire logic [3:0] cfgNumBuf,
  input wire logic [5:0] cfgBufSize,
  input wire logic [3:0] cfgStopThr,
  input wire logic [3:0] cfgGoThr,
  input wire logic [7:0] cfgXonChar,
  input wire logic [7:0] cfgXoffChar,
  input wire logic [7:0] cfgCountStart,
  input wire logic [7:0] cfgEscStart,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  output logic termValid,
  output logic [7:0] termData,
  input wire logic termReady,
  output logic pktValid,
  output logic [7:0] pktData,
  output logic pktRoute,
  input wire logic pktReady,
  output logic parityErr,
  output logic framingErr,
  output logic overrunErr,
  output logic [15:0] lostCount,
  output logic [3:0] freeBuffers,
  output logic suspended
);
  // Parity bit for a character: data ones folded with the odd sense.
  function automatic logic parBit(input logic [7:0] d, input logic seven,
                                  input logic odd);
    parBit = (seven ? ^d[6:0] : ^d) ^ odd; // R11 R12
  endfunction

  // Byte address of a position inside a buffer of the pool.
  function automatic logic [8:0] bufAddr(input logic [2:0] idx,
                                         input logic [5:0] pos);
    bufAddr = 9'(idx * `HSRFD_BUF_STRIDE) + {3'h0, pos};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Configuration storage.
  logic [15:0] baudDiv_q;
  logic [1:0] parity_q;
  logic seven_q, flowOut_q, hear_q;
  logic [3:0] numBuf_q, stopThr_q, goThr_q;
  logic [5:0] bufSize_q;
  logic [7:0] xon_q, xoff_q, cntStart_q, escStart_q;

  // Load new settings on cfgLoad; zero or oversized pool sizes fall back to the defaults.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      baudDiv_q <= `HSRFD_BAUD_DIV_DEF; // R27
      parity_q <= 2'(hsrfd_pkg::PAR_NONE);
      seven_q <= 1'b0;
      flowOut_q <= 1'b1;
      hear_q <= 1'b0; // R8
      numBuf_q <= `HSRFD_NUM_BUF_DEF; // R1
      bufSize_q <= `HSRFD_BUF_SIZE_DEF; // R1
      stopThr_q <= `HSRFD_STOP_THR_DEF;
      goThr_q <= `HSRFD_GO_THR_DEF;
      xon_q <= `HSRFD_XON_DEF; // R24
      xoff_q <= `HSRFD_XOFF_DEF; // R23
      cntStart_q <= `HSRFD_CNT_START_DEF;
      escStart_q <= `HSRFD_ESC_START_DEF;
    end else if (cfgLoad) begin
      baudDiv_q <= (cfgBaudDiv < 16'h0004) ? 16'h0004 : cfgBaudDiv;
      parity_q <= cfgParity; // R14
      seven_q <= cfgSevenBit;
      flowOut_q <= cfgFlowOut;
      hear_q <= cfgHearFlow;
      numBuf_q <= (cfgNumBuf == 4'h0 || cfgNumBuf > `HSRFD_NUM_BUF_DEF) ?
                  `HSRFD_NUM_BUF_DEF : cfgNumBuf; // R27
      bufSize_q <= (cfgBufSize == 6'h00 || cfgBufSize > `HSRFD_BUF_SIZE_DEF)
                   ? `HSRFD_BUF_SIZE_DEF : cfgBufSize;
      stopThr_q <= cfgStopThr;
      goThr_q <= cfgGoThr;
      xon_q <= cfgXonChar;
      xoff_q <= cfgXoffChar;
      cntStart_q <= cfgCountStart; // R21
      escStart_q <= cfgEscStart; // R21
    end
  end

  logic parEn, parOdd;
  logic [3:0] nBits, frameBits;
  assign parEn = parity_q != 2'(hsrfd_pkg::PAR_NONE);
  assign parOdd = parity_q == 2'(hsrfd_pkg::PAR_ODD);
  assign nBits = seven_q ? 4'h7 : 4'h8;
  assign frameBits = nBits + {3'h0, parEn} + 4'h2;

  ////////////////////////////////////////////////////////////////////////
  // Receiver and holding register.
  hsrfd_pkg::hsrfd_rx_t rxSt_q, rxSt_d;
  logic [15:0] rxCnt_q, rxCnt_d;
  logic [2:0] rxBit_q, rxBit_d;
  logic [7:0] rxSh_q, rxSh_d, hold_q, hold_d;
  logic rxPar_q, rxPar_d, holdValid_q, holdValid_d, holdTake;
  logic parErr_q, parErr_d, frmErr_q, frmErr_d, ovrErr_q, ovrErr_d;
  logic rxTick, rxDone;

  assign rxTick = rxCnt_q == baudDiv_q - 16'h0001;
  assign rxDone = (rxSt_q == hsrfd_pkg::RX_STOP) && rxTick;

  // Frame hunting, mid-bit sampling, error flags and the holding register.
  always_comb begin
    rxSt_d = rxSt_q;
    rxCnt_d = rxTick ? 16'h0000 : rxCnt_q + 16'h0001;
    rxBit_d = rxBit_q;
    rxSh_d = rxSh_q;
    rxPar_d = rxPar_q;
    hold_d = hold_q;
    holdValid_d = holdValid_q && !holdTake;
    parErr_d = parErr_q;
    frmErr_d = frmErr_q;
    ovrErr_d = ovrErr_q;
    unique case (rxSt_q)
      hsrfd_pkg::RX_IDLE: begin
        rxCnt_d = 16'h0000;
        if (!serialIn) begin
          rxSt_d = hsrfd_pkg::RX_START; // R15
        end
      end
      hsrfd_pkg::RX_START: begin
        if (rxCnt_q == {1'b0, baudDiv_q[15:1]}) begin
          rxCnt_d = 16'h0000;
          rxBit_d = 3'h0;
          rxSh_d = 8'h00;
          rxSt_d = serialIn ? hsrfd_pkg::RX_IDLE : hsrfd_pkg::RX_DATA;
        end
      end
      hsrfd_pkg::RX_DATA: begin
        if (rxTick) begin
          rxSh_d[rxBit_q] = serialIn; // R11
          rxBit_d = rxBit_q + 3'h1;
          if ({1'b0, rxBit_q} == nBits - 4'h1) begin
            rxSt_d = parEn ? hsrfd_pkg::RX_PAR : hsrfd_pkg::RX_STOP;
          end
        end
      end
      hsrfd_pkg::RX_PAR: begin
        if (rxTick) begin
          rxPar_d = serialIn;
          rxSt_d = hsrfd_pkg::RX_STOP;
        end
      end
      hsrfd_pkg::RX_STOP: begin
        if (rxTick) begin
          rxSt_d = hsrfd_pkg::RX_IDLE;
          hold_d = rxSh_q;
          holdValid_d = 1'b1;
          if (holdValid_q && !holdTake) begin
            ovrErr_d = 1'b1; // R17
          end
          if (!serialIn) begin
            frmErr_d = 1'b1; // R16
          end
          if (parEn && parBit(rxSh_q, seven_q, parOdd) != rxPar_q) begin
            parErr_d = 1'b1; // R13
          end
        end
      end
      default: rxSt_d = hsrfd_pkg::RX_IDLE;
    endcase
  end

  // Receiver registers; error flags clear only at reboot.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rxSt_q <= hsrfd_pkg::RX_IDLE;
      rxCnt_q <= 16'h0000;
      rxBit_q <= 3'h0;
      rxSh_q <= 8'h00;
      rxPar_q <= 1'b0;
      hold_q <= 8'h00;
      holdValid_q <= 1'b0;
      parErr_q <= 1'b0; // R10
      frmErr_q <= 1'b0;
      ovrErr_q <= 1'b0;
    end else begin
      rxSt_q <= rxSt_d;
      rxCnt_q <= rxCnt_d;
      rxBit_q <= rxBit_d;
      rxSh_q <= rxSh_d;
      rxPar_q <= rxPar_d;
      hold_q <= hold_d;
      holdValid_q <= holdValid_d;
      parErr_q <= parErr_d;
      frmErr_q <= frmErr_d;
      ovrErr_q <= ovrErr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffer pool fill, drain and suspension from received flow characters.
  logic [2:0] wrIdx_q, wrIdx_d, rdIdx_q, rdIdx_d;
  logic [5:0] fill_q, fill_d, rdPos_q, rdPos_d;
  logic [5:0] bufLen_q [0:7];
  logic [5:0] bufLen_d [0:7];
  logic [3:0] used_q, used_d, freeNow, freePrev_q;
  logic [15:0] lost_q, lost_d;
  logic [20:0] idle_q, idle_d, idleLimit;
  logic susp_q, susp_d, memWr, memRd, sValid_q, sValid_d, sTake;
  logic flowChar, commit, bufDone, idleCommit;
  logic [7:0] memRdData;

  // The writer pauses one cycle on an idle-timeout commit, so a character
  // landing exactly then overwrites an unread one.
  assign idleCommit = fill_q != 6'h00 && idle_q >= idleLimit; // R26
  assign holdTake = holdValid_q && !idleCommit;
  assign flowChar = hear_q && (hold_q == xoff_q || hold_q == xon_q);
  assign idleLimit = 21'(`HSRFD_IDLE_CHARS * frameBits * baudDiv_q);
  assign memWr = holdTake && !flowChar && used_q != numBuf_q;
  assign bufDone = memRd && rdPos_q + 6'h01 == bufLen_q[rdIdx_q];
  assign memRd = used_q != 4'h0 && (!sValid_q || sTake);
  assign freeNow = numBuf_q - used_q - {3'h0, fill_q != 6'h00};

  // Fill, commit on full or idle timeout, drain whole buffers in order.
  always_comb begin
    wrIdx_d = wrIdx_q;
    fill_d = fill_q;
    lost_d = lost_q;
    susp_d = susp_q;
    bufLen_d = bufLen_q;
    rdIdx_d = rdIdx_q;
    rdPos_d = rdPos_q;
    commit = idleCommit; // R26
    idle_d = (holdValid_q || fill_q == 6'h00) ? 21'h000000 :
             idle_q + 21'h000001;
    if (cfgLoad || cfgQuery) begin
      susp_d = 1'b0; // R7
    end
    if (holdTake && flowChar) begin
      susp_d = hold_q == xoff_q; // R6
    end else if (holdTake && used_q == numBuf_q) begin
      if (lost_q != `HSRFD_LOST_MAX) begin
        lost_d = lost_q + 16'h0001; // R3 R9
      end
    end else if (memWr) begin
      fill_d = fill_q + 6'h01; // R2
      if (fill_q + 6'h01 == bufSize_q) begin
        commit = 1'b1;
      end
    end
    if (commit) begin
      bufLen_d[wrIdx_q] = fill_d;
      fill_d = 6'h00;
      wrIdx_d = (4'(wrIdx_q) + 4'h1 == numBuf_q) ? 3'h0 : wrIdx_q + 3'h1;
    end
    if (memRd) begin
      rdPos_d = bufDone ? 6'h00 : rdPos_q + 6'h01;
    end
    if (bufDone) begin
      rdIdx_d = (4'(rdIdx_q) + 4'h1 == numBuf_q) ? 3'h0 : rdIdx_q + 3'h1;
    end
    used_d = used_q + {3'h0, commit} - {3'h0, bufDone};
    sValid_d = memRd || (sValid_q && !sTake);
  end

  // Pool registers.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrIdx_q <= 3'h0;
      rdIdx_q <= 3'h0;
      fill_q <= 6'h00;
      rdPos_q <= 6'h00;
      used_q <= 4'h0;
      freePrev_q <= `HSRFD_NUM_BUF_DEF;
      lost_q <= 16'h0000;
      idle_q <= 21'h000000;
      susp_q <= 1'b0;
      sValid_q <= 1'b0;
      bufLen_q <= '{default: 6'h00};
    end else begin
      wrIdx_q <= wrIdx_d;
      rdIdx_q <= rdIdx_d;
      fill_q <= fill_d;
      rdPos_q <= rdPos_d;
      used_q <= used_d;
      freePrev_q <= freeNow;
      lost_q <= lost_d;
      idle_q <= idle_d;
      susp_q <= susp_d;
      sValid_q <= sValid_d;
      bufLen_q <= bufLen_d;
    end
  end

  hsrfd_buf_mem uMem (
    .clk(clk),
    .wrEn(memWr),
    .wrAddr(bufAddr(wrIdx_q, fill_q)),
    .wrData(hold_q),
    .rdEn(memRd),
    .rdAddr(bufAddr(rdIdx_q, rdPos_q)),
    .rdData(memRdData)
  );

  ////////////////////////////////////////////////////////////////////////
  // Count-mode and escape-mode splitters on the drained byte stream.
  hsrfd_pkg::hsrfd_split_t sp_q, sp_d;
  logic [7:0] cnt_q, cnt_d;
  logic route_q, route_d, toTerm, toPkt;

  // Start characters in non-count states are swallowed; count data is
  // forwarded blindly until the length runs out.
  always_comb begin
    sp_d = sp_q;
    cnt_d = cnt_q;
    route_d = route_q;
    toTerm = 1'b0;
    toPkt = 1'b0;
    sTake = 1'b0;
    if (sValid_q) begin
      unique case (sp_q)
        hsrfd_pkg::SP_CNT_LEN: begin
          sTake = 1'b1;
          cnt_d = memRdData;
          route_d = 1'b1; // R20
          sp_d = (memRdData == 8'h00) ? hsrfd_pkg::SP_TERM :
                 hsrfd_pkg::SP_CNT_DATA;
        end
        hsrfd_pkg::SP_CNT_DATA: begin
          toPkt = 1'b1; // R22
          sTake = pktReady;
          if (pktReady) begin
            route_d = 1'b0;
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
              sp_d = hsrfd_pkg::SP_TERM;
            end
          end
        end
        default: begin
          if (memRdData == cntStart_q) begin
            sTake = 1'b1;
            sp_d = hsrfd_pkg::SP_CNT_LEN; // R18
          end else if (memRdData == escStart_q) begin
            sTake = 1'b1;
            route_d = 1'b1; // R20
            sp_d = hsrfd_pkg::SP_ESC; // R19
          end else if (sp_q == hsrfd_pkg::SP_ESC) begin
            toPkt = 1'b1;
            sTake = pktReady;
            route_d = route_q && !pktReady;
          end else begin
            toTerm = 1'b1; // R18 R19
            sTake = termReady;
          end
        end
      endcase
    end
  end

  // Splitter registers.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sp_q <= hsrfd_pkg::SP_TERM;
      cnt_q <= 8'h00;
      route_q <= 1'b0;
    end else begin
      sp_q <= sp_d;
      cnt_q <= cnt_d;
      route_q <= route_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter with suspend and resume character requests.
  hsrfd_pkg::hsrfd_tx_t txSt_q, txSt_d;
  logic [15:0] txCnt_q, txCnt_d;
  logic [3:0] txBit_q, txBit_d;
  logic [10:0] txSh_q, txSh_d;
  logic txOut_q, txOut_d, xoffPend_q, xoffPend_d, xonPend_q, xonPend_d;
  logic [7:0] txChar;
  logic txStart;

  assign txReady = txSt_q == hsrfd_pkg::TX_IDLE && !xoffPend_q &&
                   !xonPend_q && !susp_q; // R6 R25
  assign txStart = txSt_q == hsrfd_pkg::TX_IDLE &&
                   (xoffPend_q || xonPend_q || (txValid && !susp_q));
  assign txChar = xoffPend_q ? xoff_q : (xonPend_q ? xon_q : txData);

  // Threshold crossings raise requests; frames shift out lsb first.
  always_comb begin
    txSt_d = txSt_q;
    txCnt_d = txCnt_q;
    txBit_d = txBit_q;
    txSh_d = txSh_q;
    txOut_d = txOut_q;
    xoffPend_d = xoffPend_q;
    xonPend_d = xonPend_q;
    if (txStart) begin
      xoffPend_d = 1'b0;
      xonPend_d = xoffPend_q ? xonPend_q : 1'b0;
      txSh_d = seven_q ? {2'b11, parBit(txChar, 1'b1, parOdd), txChar[6:0],
                          1'b0}
                       : {1'b1, parBit(txChar, 1'b0, parOdd), txChar, 1'b0};
      if (!parEn) begin
        txSh_d = seven_q ? {3'b111, txChar[6:0], 1'b0}
                         : {2'b11, txChar, 1'b0};
      end
      txOut_d = 1'b0; // R15
      txCnt_d = 16'h0000;
      txBit_d = 4'h1;
      txSt_d = hsrfd_pkg::TX_SHIFT;
    end else if (txSt_q == hsrfd_pkg::TX_SHIFT) begin
      txCnt_d = txCnt_q + 16'h0001;
      if (txCnt_q == baudDiv_q - 16'h0001) begin
        txCnt_d = 16'h0000;
        if (txBit_q == frameBits) begin
          txOut_d = 1'b1;
          txSt_d = hsrfd_pkg::TX_IDLE;
        end else begin
          txOut_d = txSh_q[txBit_q]; // R11
          txBit_d = txBit_q + 4'h1;
        end
      end
    end
    if (flowOut_q && freeNow != freePrev_q) begin
      if (freeNow < freePrev_q && freeNow == stopThr_q) begin
        xoffPend_d = 1'b1; // R4
        xonPend_d = 1'b0;
      end
      if (freeNow > freePrev_q && freeNow == goThr_q) begin
        xonPend_d = 1'b1; // R5
        xoffPend_d = 1'b0;
      end
    end
  end

  // Transmitter registers; the line rests at mark.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      txSt_q <= hsrfd_pkg::TX_IDLE;
      txCnt_q <= 16'h0000;
      txBit_q <= 4'h0;
      txSh_q <= 11'h7ff;
      txOut_q <= 1'b1;
      xoffPend_q <= 1'b0;
      xonPend_q <= 1'b0;
    end else begin
      txSt_q <= txSt_d;
      txCnt_q <= txCnt_d;
      txBit_q <= txBit_d;
      txSh_q <= txSh_d;
      txOut_q <= txOut_d;
      xoffPend_q <= xoffPend_d;
      xonPend_q <= xonPend_d;
    end
  end

  assign serialOut = txOut_q;
  assign termValid = toTerm;
  assign termData = memRdData;
  assign pktValid = toPkt;
  assign pktData = memRdData;
  assign pktRoute = toPkt && route_q;
  assign parityErr = parErr_q;
  assign framingErr = frmErr_q;
  assign overrunErr = ovrErr_q;
  assign lostCount = lost_q;
  assign freeBuffers = freeNow;
  assign suspended = susp_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_drop;
    holdTake && !flowChar && used_q == numBuf_q && lost_q != 16'h0000 &&
    lost_q != `HSRFD_LOST_MAX |=> !$past(memWr) && lost_q == $past(lost_q) +
    16'h0001;
  endproperty
  a_drop: assert property (p_drop) else $error("drop not counted"); // R3

  property p_susp;
    hear_q && holdTake && hold_q == xoff_q |=> susp_q [*2] or
    (susp_q ##1 !susp_q);
  endproperty
  a_susp: assert property (p_susp) else $error("xoff not obeyed"); // R6

  property p_clear;
    (cfgLoad || cfgQuery) && !(holdTake && flowChar) |=> !susp_q;
  endproperty
  a_clear: assert property (p_clear) else $error("suspend kept"); // R7

  property p_hold;
    susp_q && !xoffPend_q && !xonPend_q |-> !txStart;
  endproperty
  a_hold: assert property (p_hold) else $error("tx while held"); // R25

  property p_parity;
    rxDone && parEn && parBit(rxSh_q, seven_q, parOdd) != rxPar_q
    |=> parErr_q [*3];
  endproperty
  a_parity: assert property (p_parity) else $error("parity missed"); // R13

  property p_frame;
    rxDone && !serialIn |=> frmErr_q;
  endproperty
  a_frame: assert property (p_frame) else $error("framing missed"); // R16

  property p_overrun;
    rxDone && holdValid_q && idleCommit |=> ovrErr_q && holdValid_q;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed"); // R17

  property p_xoff;
    flowOut_q && freeNow < freePrev_q && freeNow == stopThr_q
    |=> xoffPend_q ##[0:2] !txReady;
  endproperty
  a_xoff: assert property (p_xoff) else $error("xoff not raised"); // R4

  property p_count;
    sp_q == hsrfd_pkg::SP_CNT_DATA |-> !termValid;
  endproperty
  a_count: assert property (p_count) else $error("count leak"); // R22
endmodule

/* File: dv/hsrfd_host_model.sv */
// Behavioural model of the host computer on the far side of the serial line.
module hsrfd_host_model #(
  parameter int DIV = 8
) (
  input wire logic clk,
  output logic serialIn,
  input wire logic serialOut
);
  timeunit 1ns;
  timeprecision 1ps;
  `include "hsrfd_consts.svh"
  logic held = 1'b0;
  logic [7:0] rxQ[$];
  initial serialIn = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // Drives one bit time on the line, changing only at a rising edge.
  task automatic bitOut(input logic v);
    serialIn <= v;
    repeat (DIV) @(posedge clk);
  endtask
  // Sends one frame; a held host waits for resume before starting it.
  task automatic send(input logic [7:0] b, input logic [1:0] par,
                      input logic badPar, input logic badStop);
    int n;
    n = 0;
    while (held && n < 20000) begin
      @(posedge clk);
      n++;
    end
    bitOut(1'b0);
    for (int i = 0; i < 8; i++) bitOut(b[i]);
    if (par != 2'h0) bitOut((^b) ^ (par == 2'h2) ^ badPar);
    bitOut(~badStop);
    bitOut(1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Decodes frames sent by the device and obeys its flow characters.
  always begin
    logic [7:0] d;
    @(negedge serialOut);
    repeat (DIV / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge clk);
      d[i] = serialOut;
    end
    repeat (DIV) @(posedge clk);
    rxQ.push_back(d);
    if (d === `HSRFD_XOFF_DEF) held = 1'b1;
    if (d === `HSRFD_XON_DEF) held = 1'b0;
  end
endmodule

/* File: dv/tb_top.sv */
// Self-checking testbench of the host serial receive and splitter block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `include "hsrfd_consts.svh"
  `define CHK(a, b) begin automatic logic [31:0] ga = (a), gb = (b); \
    cmp_count++; if (ga !== gb) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, ga, gb); end end
  logic clk = 1'b0, rstn = 1'b0, sIn, sOut, cfgLoad = 1'b0, cfgQuery = 1'b0;
  logic [1:0] par = 2'h1;
  logic flowOut = 1'b0, hear = 1'b0, txValid = 1'b0, txReady;
  logic [3:0] numBuf = 4'h8, freeBuffers;
  logic [5:0] bufSize = 6'h30;
  logic [7:0] cStart = 8'h06, txData = 8'h00, termData, pktData, b;
  logic termValid, termReady = 1'b1, pktValid, pktRoute, pktReady = 1'b1;
  logic parityErr, framingErr, overrunErr, suspended, randRdy = 1'b0;
  logic fixRdy = 1'b1, seven = 1'b0;
  logic [15:0] lostCount;
  logic [8:0] termQ[$], expQ[$];
  int fails = 0, cmp_count = 0;
  always #20 clk = ~clk;
  hsrfd_host_model #(.DIV(8)) host (.clk(clk), .serialIn(sIn),
    .serialOut(sOut));
  hsrfd_serial_port dut (.clk(clk), .rstn(rstn), .serialIn(sIn),
    .serialOut(sOut), .cfgLoad(cfgLoad), .cfgQuery(cfgQuery),
    .cfgBaudDiv(16'h0008), .cfgParity(par), .cfgSevenBit(seven),
    .cfgFlowOut(flowOut), .cfgHearFlow(hear), .cfgNumBuf(numBuf),
    .cfgBufSize(bufSize), .cfgStopThr(`HSRFD_STOP_THR_DEF),
    .cfgGoThr(`HSRFD_GO_THR_DEF), .cfgXonChar(`HSRFD_XON_DEF),
    .cfgXoffChar(`HSRFD_XOFF_DEF), .cfgCountStart(cStart),
    .cfgEscStart(`HSRFD_ESC_START_DEF), .txValid(txValid), .txData(txData),
    .txReady(txReady), .termValid(termValid), .termData(termData),
    .termReady(termReady), .pktValid(pktValid), .pktData(pktData),
    .pktRoute(pktRoute), .pktReady(pktReady), .parityErr(parityErr),
    .framingErr(framingErr), .overrunErr(overrunErr), .lostCount(lostCount),
    .freeBuffers(freeBuffers), .suspended(suspended));
  ////////////////////////////////////////////////////////////////////////////
  // Records every byte taken on either output stream, route flag on top.
  always @(posedge clk) begin
    if (termValid === 1'b1 && termReady) termQ.push_back({1'b0, termData});
    if (pktValid === 1'b1 && pktReady) termQ.push_back({pktRoute, pktData});
    termReady <= randRdy ? 1'($urandom_range(1)) : fixRdy;
    pktReady <= randRdy ? 1'($urandom_range(1)) : 1'b1;
  end
  // Loads the configuration with a one-cycle strobe.
  task automatic cfg(input logic [3:0] nb, input logic [5:0] bs,
                     input logic fo, input logic hf);
    @(posedge clk);
    {numBuf, bufSize, flowOut, hear, cfgLoad} <= {nb, bs, fo, hf, 1'b1};
    @(posedge clk);
    cfgLoad <= 1'b0;
  endtask
  // Sends a byte, optionally expecting it on a stream with a route flag.
  task automatic put(input logic [7:0] v, input logic e, input logic r);
    host.send(v, par, 1'b0, 1'b0);
    if (e) expQ.push_back({r, v});
  endtask
  // Lets buffers time out and drain, then compares both streams.
  task automatic drain();
    repeat (400) @(posedge clk);
    `CHK(termQ.size(), expQ.size())
    foreach (expQ[i]) `CHK(termQ[i], expQ[i])
    termQ.delete();
    expQ.delete();
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence of scenarios.
  initial begin
    void'($urandom(92463));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK({sOut, txReady, parityErr, framingErr, suspended}, 5'h18)
    `CHK(freeBuffers, 4'h8)
    `CHK(lostCount, 16'h0000)
    randRdy <= 1'b1;
    // Random terminal traffic under each parity setting.
    for (int p = 0; p < 3; p++) begin
      par <= 2'(p);
      cfg(4'h8, 6'h30, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
        b = 8'($urandom);
        if (b == 8'h06 || b == 8'h1c) b ^= 8'h80;
        put(b, 1'b1, 1'b0);
      end
      drain();
    end
    // Count packet holding an escape start, then escape mode, then back.
    put(8'h06, 1'b0, 1'b0);
    put(8'h03, 1'b0, 1'b0);
    put(8'h41, 1'b1, 1'b1);
    put(8'h1c, 1'b1, 1'b0);
    put(8'h42, 1'b1, 1'b0);
    put(8'h1c, 1'b0, 1'b0);
    put(8'h43, 1'b1, 1'b1);
    put(8'h44, 1'b1, 1'b0);
    put(8'h06, 1'b0, 1'b0);
    put(8'h00, 1'b0, 1'b0);
    put(8'h45, 1'b1, 1'b0);
    drain();
    // A reprogrammed count start character.
    cStart <= 8'h05;
    cfg(4'h8, 6'h30, 1'b0, 1'b0);
    put(8'h05, 1'b0, 1'b0);
    put(8'h01, 1'b0, 1'b0);
    put(8'h06, 1'b1, 1'b1);
    drain();
    // Error flags from bad parity and a missing stop bit.
    `CHK({parityErr, framingErr}, 2'h0)
    host.send(8'h5a, par, 1'b1, 1'b0);
    `CHK({parityErr, framingErr}, 2'h2)
    host.send(8'h5b, par, 1'b0, 1'b1);
    `CHK({parityErr, framingErr}, 2'h3)
    repeat (400) @(posedge clk);
    termQ.delete();
    // Seven data bits with even parity; the host sends parity as bit 7.
    seven <= 1'b1;
    par <= 2'h1;
    cfg(4'h8, 6'h30, 1'b0, 1'b0);
    b = 8'($urandom) | 8'h40;
    host.send({^b[6:0], b[6:0]}, 2'h0, 1'b0, 1'b0);
    expQ.push_back({2'h0, b[6:0]});
    drain();
    // Pool of one small buffer with the reader stalled drops the rest.
    randRdy <= 1'b0;
    fixRdy <= 1'b0;
    seven <= 1'b0;
    cfg(4'h1, 6'h02, 1'b0, 1'b0);
    for (int i = 0; i < 5; i++) put(8'(8'h60 + i), i < 2, 1'b0);
    `CHK(lostCount, 16'h0003)
    `CHK(freeBuffers, 4'h0)
    fixRdy <= 1'b1;
    drain();
    // Received suspend blocks sending until the settings are queried.
    cfg(4'h8, 6'h30, 1'b0, 1'b1);
    put(`HSRFD_XOFF_DEF, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    `CHK({suspended, txReady}, 2'h2)
    cfgQuery <= 1'b1;
    @(posedge clk);
    cfgQuery <= 1'b0;
    @(posedge clk);
    `CHK({suspended, txReady}, 2'h1)
    drain();
    // User transmit frame decoded by the host.
    host.rxQ.delete();
    par <= 2'h0;
    cfg(4'h3, 6'h02, 1'b1, 1'b0);
    b = 8'($urandom);
    txData <= b;
    txValid <= 1'b1;
    do @(posedge clk); while (txReady !== 1'b1);
    txValid <= 1'b0;
    repeat (200) @(posedge clk);
    `CHK(host.rxQ.pop_front(), b)
    // Filling the pool to the stop threshold sends suspend, draining it sends resume.
    fixRdy <= 1'b0;
    for (int i = 0; i < 3; i++) put(8'(8'h70 + i), 1'b1, 1'b0);
    repeat (300) @(posedge clk);
    `CHK(host.rxQ.pop_front(), `HSRFD_XOFF_DEF)
    fixRdy <= 1'b1;
    drain();
    `CHK(host.rxQ.pop_front(), `HSRFD_XON_DEF)
    `CHK(overrunErr, 1'b0)
    print_verdict();
  end
endmodule
